/* verilog/aout_pkg.sv */
// Function
// - two consecutive setpoint registers, channel one first
// - one resolution mode for both channels
// - zero 2048 or 0; full 4048/+32000
// - timeout behaviour only in normal stop
// - power down or kernel forces fail-safe
// - hold-last keeps the last output level
// - user-defined loads per-channel stored word
package aout_pkg;
    // ==========================================
    // register map
    localparam logic [7:0]  OFS_SETPOINT_ONE = 8'h00;
    localparam logic [7:0]  OFS_SETPOINT_TWO = 8'h04;
    localparam logic [7:0]  OFS_CONTROL      = 8'h08;
    localparam logic [7:0]  OFS_USER_ONE     = 8'h0c;
    localparam logic [7:0]  OFS_USER_TWO     = 8'h10;
    localparam logic [7:0]  OFS_STATUS       = 8'h14;
    localparam logic [7:0]  OFS_LEVEL_ONE    = 8'h18;
    localparam logic [7:0]  OFS_LEVEL_TWO    = 8'h1c;
    // ==========================================
    // fields
    localparam int          CTL_MODE_BIT     = 0;
    localparam int          CTL_TIMEOUT_BIT  = 1;
    localparam int          STS_STATE_LSB    = 0;
    localparam int          STS_FAILSAFE_BIT = 2;
    localparam int          STS_TIMEOUT_BIT  = 3;
    localparam int          NUM_CHANNELS     = 2;
    // ==========================================
    // reset values and codes
    localparam logic [15:0] SETPOINT_RESET   = 16'h0000;
    localparam logic [15:0] USER_RESET       = 16'h0000;
    localparam logic [1:0]  CONTROL_RESET    = 2'h0;
    localparam logic [15:0] FAILSAFE_LEVEL   = 16'h0000;
    localparam logic [16:0] ZERO_CODE_12     = 17'h00800;
    localparam logic [15:0] FULL_CODE_12     = 16'h0fd0;
    localparam logic [15:0] FULL_CODE_SIGNED = 16'h7d00;

    typedef enum logic [1:0] {
        PLC_RUN       = 2'b00,
        PLC_STOP      = 2'b01,
        PLC_KERNEL    = 2'b10,
        PLC_POWERDOWN = 2'b11
    } plc_state_t;

    typedef enum logic {
        MODE_UNSIGNED_12 = 1'b0,
        MODE_SIGNED_15   = 1'b1
    } res_mode_t;

    typedef enum logic {
        TIMEOUT_HOLD_LAST = 1'b0,
        TIMEOUT_USER_DEF  = 1'b1
    } timeout_sel_t;
endpackage

/* verilog/analog_output_timeout_control.sv */
// Decided for this implementation: register access over APB and the placing of the registers.
module analog_output_timeout_control
    import aout_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // controller state
    input  wire logic [1:0]  plc_state_i,
    // analog setpoints, signed full scale +-32000
    output logic      [15:0] level_one_o,
    output logic      [15:0] level_two_o,
    output logic             failsafe_o,
    output logic             timeout_o
);

    // ==========================================
    // register state
    logic [15:0]  setpoint_reg [NUM_CHANNELS];
    logic [15:0]  user_reg     [NUM_CHANNELS];
    logic [15:0]  level_reg    [NUM_CHANNELS];
    logic [15:0]  conv_set     [NUM_CHANNELS];
    logic [15:0]  conv_user    [NUM_CHANNELS];
    logic [15:0]  level_next   [NUM_CHANNELS];
    res_mode_t    mode_reg;
    timeout_sel_t timeout_reg;
    plc_state_t   plc_state;
    logic [31:0]  prdata_next;
    logic         err_next;
    logic         map_hit;
    logic         ro_hit;
    logic         wr_en;
    logic         wr_control;
    logic         wr_setpoint  [NUM_CHANNELS];
    logic         wr_user      [NUM_CHANNELS];
    logic         setup_phase;

    assign plc_state   = plc_state_t'(plc_state_i);
    assign setup_phase = psel_i && !penable_i;
    assign wr_en       = psel_i && penable_i && pready_o && pwrite_i;
    assign wr_control  = wr_en && (paddr_i == OFS_CONTROL);

    // ==========================================
    // code conversion
    // 12-bit codes scale by 16 so 4048 lands exactly on +32000
    function automatic logic [15:0] to_level(input logic [15:0] code, input res_mode_t mode);
        logic [16:0] diff;
        diff = 17'h00000;
        if (mode == MODE_SIGNED_15) begin
            to_level = code;
        end else begin
            diff     = {5'h00, code[11:0]} - ZERO_CODE_12;
            to_level = {diff[11:0], 4'h0};
        end
    endfunction

    // ==========================================
    // apb setup phase decode
    always_comb begin
        prdata_next = 32'h0000_0000;
        case (paddr_i)
            OFS_SETPOINT_ONE: prdata_next = 32'h0000_0000;
            OFS_SETPOINT_TWO: prdata_next = 32'h0000_0000;
            OFS_CONTROL: begin
                prdata_next[CTL_MODE_BIT]    = mode_reg;
                prdata_next[CTL_TIMEOUT_BIT] = timeout_reg;
            end
            OFS_USER_ONE:     prdata_next = {16'h0000, user_reg[0]};
            OFS_USER_TWO:     prdata_next = {16'h0000, user_reg[1]};
            OFS_STATUS: begin
                prdata_next[STS_STATE_LSB+1:STS_STATE_LSB] = plc_state_i;
                prdata_next[STS_FAILSAFE_BIT] = failsafe_o;
                prdata_next[STS_TIMEOUT_BIT]  = timeout_o;
            end
            OFS_LEVEL_ONE:    prdata_next = {16'h0000, level_reg[0]};
            OFS_LEVEL_TWO:    prdata_next = {16'h0000, level_reg[1]};
            default:          prdata_next = 32'h0000_0000;
        endcase
    end

    // ==========================================
    // apb error decode
    // status and levels are read only: a write there must not look
    // like it took, or software could believe it forced a level
    always_comb begin
        map_hit = 1'b1;
        ro_hit  = 1'b0;
        case (paddr_i)
            OFS_SETPOINT_ONE: map_hit = 1'b1;
            OFS_SETPOINT_TWO: map_hit = 1'b1;
            OFS_CONTROL:      map_hit = 1'b1;
            OFS_USER_ONE:     map_hit = 1'b1;
            OFS_USER_TWO:     map_hit = 1'b1;
            OFS_STATUS:       ro_hit  = 1'b1;
            OFS_LEVEL_ONE:    ro_hit  = 1'b1;
            OFS_LEVEL_TWO:    ro_hit  = 1'b1;
            default:          map_hit = 1'b0;
        endcase
    end

    assign err_next = !map_hit || (pwrite_i && ro_hit);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (setup_phase) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : prdata_next;
            pslverr_o <= err_next;
        end
    end

    // zero wait states; answer is prepared in the setup cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= 1'b1;
        end
    end

    // ==========================================
    // configuration registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg    <= res_mode_t'(CONTROL_RESET[CTL_MODE_BIT]);
            timeout_reg <= timeout_sel_t'(CONTROL_RESET[CTL_TIMEOUT_BIT]);
        end else if (wr_control) begin
            mode_reg    <= res_mode_t'(pwdata_i[CTL_MODE_BIT]);
            timeout_reg <= timeout_sel_t'(pwdata_i[CTL_TIMEOUT_BIT]);
        end
    end

    // ==========================================
    // per channel datapath
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            localparam logic [7:0] SET_OFS  = OFS_SETPOINT_ONE + 8'(4 * ch);
            localparam logic [7:0] USER_OFS = OFS_USER_ONE + 8'(4 * ch);

            // strobes decoded once so each store sees one clean enable
            assign wr_setpoint[ch] = wr_en && (paddr_i == SET_OFS);
            assign wr_user[ch]     = wr_en && (paddr_i == USER_OFS);

            // setpoints are stored in any state; they only reach the output in run
            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    setpoint_reg[ch] <= SETPOINT_RESET;
                end else if (wr_setpoint[ch]) begin
                    setpoint_reg[ch] <= pwdata_i[15:0];
                end
            end

            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    user_reg[ch] <= USER_RESET;
                end else if (wr_user[ch]) begin
                    user_reg[ch] <= pwdata_i[15:0];
                end
            end

            assign conv_set[ch]  = to_level(setpoint_reg[ch], mode_reg);
            assign conv_user[ch] = to_level(user_reg[ch], mode_reg);

            always_comb begin
                level_next[ch] = level_reg[ch];
                case (plc_state)
                    PLC_RUN: level_next[ch] = conv_set[ch];
                    PLC_STOP: begin
                        if (timeout_reg == TIMEOUT_USER_DEF) begin
                            level_next[ch] = conv_user[ch];
                        end else begin
                            level_next[ch] = level_reg[ch];
                        end
                    end
                    PLC_KERNEL:    level_next[ch] = FAILSAFE_LEVEL;
                    PLC_POWERDOWN: level_next[ch] = FAILSAFE_LEVEL;
                    default:       level_next[ch] = FAILSAFE_LEVEL;
                endcase
            end

            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    level_reg[ch] <= FAILSAFE_LEVEL;
                end else begin
                    level_reg[ch] <= level_next[ch];
                end
            end
        end
    endgenerate

    // ==========================================
    // outputs and state flags
    assign level_one_o = level_reg[0];
    assign level_two_o = level_reg[1];

    // flags lag the state input by one edge, matching the levels
    // fail-safe is up in reset: outputs are safe before any state is seen
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            failsafe_o <= 1'b1;
        end else begin
            failsafe_o <= (plc_state == PLC_KERNEL) || (plc_state == PLC_POWERDOWN);
        end
    end

    // only a normal stop counts; kernel and power down never show timeout
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            timeout_o <= 1'b0;
        end else begin
            timeout_o <= (plc_state == PLC_STOP);
        end
    end

endmodule

/* test/aout_assertions.sv */
// ====
// checker, shadows only channel one
module aout_checker
    import aout_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic        pready_o,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    // controller state and outputs
    input wire logic [1:0]  plc_state_i,
    input wire logic [15:0] level_one_o,
    input wire logic        failsafe_o,
    input wire logic        timeout_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] sp_reg, us_reg;
    logic        md_reg, to_reg;
    logic        armed;
    // first edge after any reset still shows reset outputs; skip it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {sp_reg, us_reg, md_reg, to_reg} <= '0;
        end else if (psel_i && penable_i && pready_o && pwrite_i) begin
            if (paddr_i == OFS_SETPOINT_ONE) sp_reg <= pwdata_i[15:0];
            if (paddr_i == OFS_USER_ONE) us_reg <= pwdata_i[15:0];
            if (paddr_i == OFS_CONTROL) {to_reg, md_reg} <= pwdata_i[1:0];
        end
    end
    // 12-bit codes wrap, matching the level table
    function automatic logic [15:0] cv(input logic [15:0] c, input logic m);
        return m ? c : {c[11:0] - 12'h800, 4'h0};
    endfunction
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    property p_fs;
        armed && plc_state_i[1] |=> failsafe_o && !timeout_o && level_one_o == FAILSAFE_LEVEL;
    endproperty
    property p_to;
        armed && plc_state_i == PLC_STOP |=> timeout_o && !failsafe_o;
    endproperty
    property p_run;
        armed && plc_state_i == PLC_RUN |=> !timeout_o && !failsafe_o;
    endproperty
    property p_lvl;
        armed && plc_state_i == PLC_RUN |=> level_one_o == cv($past(sp_reg), $past(md_reg));
    endproperty
    property p_hold;
        armed && plc_state_i == PLC_STOP && !to_reg |=> $stable(level_one_o);
    endproperty
    property p_user;
        armed && plc_state_i == PLC_STOP && to_reg |=> level_one_o == cv($past(us_reg), $past(md_reg));
    endproperty
    property p_rdy;
        s_setup |=> penable_i && pready_o;
    endproperty
    property p_wo;
        s_setup ##0 (!pwrite_i && paddr_i <= OFS_SETPOINT_TWO) |=> prdata_o == 32'h0;
    endproperty
    a_fs: assert property (p_fs) else $error("failsafe wrong");
    a_to: assert property (p_to) else $error("timeout flag wrong");
    a_run: assert property (p_run) else $error("run flags wrong");
    a_lvl: assert property (p_lvl) else $error("run level wrong");
    a_hold: assert property (p_hold) else $error("hold level moved");
    a_user: assert property (p_user) else $error("user level wrong");
    a_rdy: assert property (p_rdy) else $error("no ready");
    a_wo: assert property (p_wo) else $error("setpoint readable");
endmodule

bind analog_output_timeout_control aout_checker u_aout_checker (.ref_clk_i, .rst_i, .psel_i, .penable_i,
    .pwrite_i, .pready_o, .paddr_i, .pwdata_i, .prdata_o, .plc_state_i, .level_one_o, .failsafe_o, .timeout_o);

/* test/plc_model.sv */
// ====
// controller model: apb master and state
module plc_model
    import aout_pkg::*;
(
    // clock
    input  wire logic        ref_clk_i,
    // apb answer
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    // apb request
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [7:0]  paddr_o,
    output logic      [31:0] pwdata_o,
    // controller state
    output logic      [1:0]  plc_state_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rdat;
    logic        rerr;
    initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, plc_state_o} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'b10, w, a, d};
        @(posedge ref_clk_i);
        penable_o <= 1'b1;
        do @(posedge ref_clk_i); while (pready_i !== 1'b1);
        rdat = prdata_i;
        rerr = pslverr_i;
        // idle bus shows inverted data, never the stale value
        {psel_o, penable_o, paddr_o, pwdata_o} <= {2'b00, ~a, ~d};
    endtask
    task automatic set_state(input logic [1:0] s);
        @(posedge ref_clk_i);
        plc_state_o <= s;
    endtask
endmodule

/* test/tb.sv */
module tb
    import aout_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_i = 0, rst_i = 1, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic        failsafe_o, timeout_o;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [1:0]  plc_state_i;
    logic [15:0] level_one_o, level_two_o;
    int          errors = 0, checks = 0, cyc = 0;
    logic [15:0] cd [4] = '{16'h0800, 16'h0fd0, 16'h0030, 16'h0fff};
    logic [15:0] ex [4] = '{16'h0000, 16'h7d00, 16'h8300, 16'h7ff0};
    initial forever #50 ref_clk_i = ~ref_clk_i;
    analog_output_timeout_control u_analog_output_timeout_control (.*);
    plc_model u_plc_model (.ref_clk_i, .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
        .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
        .pwdata_o(pwdata_i), .plc_state_o(plc_state_i));
    task report_and_stop;
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic ee);
        u_plc_model.xfer(w, a, d);
        if (!w) chk(u_plc_model.rdat, e);
        chk({31'h0, u_plc_model.rerr}, {31'h0, ee});
    endtask
    // one-cycle level latency, three gives margin
    task lv(input logic [15:0] e1, input logic [15:0] e2);
        repeat (3) @(posedge ref_clk_i);
        chk({16'h0, level_one_o}, {16'h0, e1});
        chk({16'h0, level_two_o}, {16'h0, e2});
    endtask
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            acc(1, OFS_SETPOINT_ONE, {16'h0, cd[i]}, 0, 0);
            acc(1, OFS_SETPOINT_TWO, {16'h0, cd[3-i]}, 0, 0);
            lv(ex[i], ex[3-i]);
        end
        acc(0, OFS_SETPOINT_ONE, 0, 32'h0, 0);
        acc(0, OFS_LEVEL_ONE, 0, 32'h7ff0, 0);
        acc(1, OFS_CONTROL, 32'h1, 0, 0);
        lv(16'h0fff, 16'h0800);
        acc(1, OFS_SETPOINT_ONE, 32'h7d00, 0, 0);
        acc(1, OFS_SETPOINT_TWO, 32'h8300, 0, 0);
        lv(16'h7d00, 16'h8300);
        u_plc_model.set_state(PLC_STOP);
        acc(1, OFS_SETPOINT_ONE, 32'h0100, 0, 0);
        lv(16'h7d00, 16'h8300);
        chk({31'h0, timeout_o}, 32'h1);
        acc(1, OFS_USER_ONE, 32'h1234, 0, 0);
        acc(1, OFS_USER_TWO, 32'h4321, 0, 0);
        acc(1, OFS_CONTROL, 32'h3, 0, 0);
        lv(16'h1234, 16'h4321);
        acc(0, OFS_CONTROL, 0, 32'h3, 0);
        acc(0, OFS_USER_TWO, 0, 32'h4321, 0);
        acc(0, OFS_LEVEL_TWO, 0, 32'h4321, 0);
        for (int s = 2; s < 4; s++) begin
            u_plc_model.set_state(s[1:0]);
            lv(FAILSAFE_LEVEL, FAILSAFE_LEVEL);
            acc(0, OFS_STATUS, 0, 32'h4 | s, 0);
        end
        u_plc_model.set_state(PLC_RUN);
        lv(16'h0100, 16'h8300);
        chk({30'h0, failsafe_o, timeout_o}, 32'h0);
        acc(1, OFS_STATUS, 32'h5, 0, 1);
        acc(0, 8'h20, 0, 32'h0, 1);
        // mid-run reset: outputs fall safe, then restart from reset codes
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk({15'h0, failsafe_o, level_one_o}, {15'h0, 1'b1, FAILSAFE_LEVEL});
        rst_i <= 1'b0;
        lv(16'h8000, 16'h8000);
        report_and_stop();
    end
endmodule
